// ---- hdl/compact_isa_branch_multi_decode.sv ----
// decode and sequencing of compressed multi-transfer, branch, jump and software interrupt
`timescale 1ns/1ps
module compact_isa_branch_multi_decode
	import compact_isa_pkg::*;
#(
	parameter int REG_IDX_W = 3             // low register group index width
) (
	input  wire logic                 clk,                 // core clock, 100 MHz
	input  wire logic                 rst_b,               // synchronous reset, active low
	input  wire logic                 instr_valid,         // instruction offered this cycle
	input  wire logic [15:0]          instr,               // compressed instruction word
	input  wire logic [31:0]          instr_addr,          // address of that instruction
	input  wire logic [31:0]          current_status_register, // live status word
	input  wire logic [31:0]          reg_rdata,           // low register read, same cycle
	input  wire logic                 mem_ready,           // memory finished the access
	input  wire logic [31:0]          mem_rdata,           // load data with mem_ready
	output logic                      busy_q,              // instruction in progress
	output logic                      done_q,              // one-cycle completion pulse
	output logic                      undef_q,             // one-cycle undefined pulse
	output logic [REG_IDX_W-1:0]      reg_rsel_q,          // low register read select
	output logic                      reg_we_q,            // low register write pulse
	output logic [REG_IDX_W-1:0]      reg_wsel_q,          // low register write select
	output logic [31:0]               reg_wdata_q,         // low register write data
	output logic                      mem_req_q,           // memory request, held to ready
	output logic                      mem_we_q,            // 1 store, 0 load
	output logic [31:0]               mem_addr_q,          // byte address of the access
	output logic [31:0]               mem_wdata_q,         // store data
	output logic                      program_counter_load_q, // one-cycle flow change
	output logic [31:0]               program_counter_target_q, // new fetch address
	output logic                      link_register_we_q,  // link write pulse
	output logic [31:0]               link_register_data_q, // link value
	output logic                      saved_status_we_q,   // saved status write pulse
	output logic [31:0]               saved_status_register_q, // copy of status word
	output logic                      wide_state_q,        // 1 after switch to wide state
	output logic                      supervisor_mode_q    // 1 after the interrupt entry
);
	// decode of the offered word
	logic                 is_multi;
	logic                 is_cond;
	logic                 is_jump;
	logic [3:0]           cond;
	logic [31:0]          short_disp;
	logic [31:0]          long_disp;
	logic [31:0]          branch_base;
	logic                 taken;
	seq_state_e           state_q;
	logic [7:0]           list_q;
	logic                 load_q;
	logic [REG_IDX_W-1:0] base_q;
	logic [31:0]          addr_q;
	logic [1:0]           refill_q;

	// field positions assume the customary layout
	assign is_multi    = instr_valid && !busy_q && instr[15:12] == MULTI_TOP; // see RL17
	assign is_cond     = instr_valid && !busy_q && instr[15:12] == COND_TOP; // see RL17
	assign is_jump     = instr_valid && !busy_q && instr[15:11] == JUMP_TOP; // see RL17
	assign cond        = instr[11:8];
	assign short_disp  = {{23{instr[7]}}, instr[7:0], 1'b0};   // see RL10
	assign long_disp   = {{20{instr[10]}}, instr[10:0], 1'b0}; // see RL15 see RL16
	assign branch_base = instr_addr + PREFETCH_BYTES;           // see RL9

	// condition evaluation on the live flags
	function automatic logic cond_true(input logic [3:0] c, input logic [31:0] sr);
		logic n;
		logic z;
		logic cy;
		logic v;
		n  = sr[FLAG_N];
		z  = sr[FLAG_Z];
		cy = sr[FLAG_C];
		v  = sr[FLAG_V];
		unique case (c)
			C_EQ: cond_true = z;                  // see RL5
			C_NE: cond_true = !z;                 // see RL5
			C_CS: cond_true = cy;                 // see RL5
			C_CC: cond_true = !cy;                // see RL5
			C_MI: cond_true = n;                  // see RL5
			C_PL: cond_true = !n;                 // see RL5
			C_VS: cond_true = v;                  // see RL5
			C_VC: cond_true = !v;                 // see RL5
			C_HI: cond_true = cy && !z;           // see RL6
			C_LS: cond_true = !cy || z;           // see RL6
			C_GE: cond_true = n == v;             // see RL7
			C_LT: cond_true = n != v;             // see RL7
			C_GT: cond_true = !z && (n == v);     // see RL8
			C_LE: cond_true = z || (n != v);      // see RL8
			default: cond_true = 1'b0;            // undefined and interrupt never branch, see RL11
		endcase
	endfunction

	assign taken = is_cond && cond_true(cond, current_status_register);

	// lowest listed register goes first so addresses rise with index
	function automatic logic [REG_IDX_W-1:0] first_set(input logic [7:0] l);
		first_set = '0;
		for (int i = 7; i >= 0; i--) begin
			if (l[i]) begin
				first_set = REG_IDX_W'(i);
			end
		end
	endfunction

	// sequencer; every change of flow ends in the refill wait so cycles match the wide form
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			state_q  <= S_IDLE;
			list_q   <= 8'h00;
			load_q   <= 1'b0;
			base_q   <= '0;
			refill_q <= 2'h0;
		end else begin
			unique case (state_q)
				S_IDLE: begin
					if (is_multi) begin
						list_q <= instr[7:0];
						load_q <= instr[LOAD_BIT];           // see RL1 see RL2
						base_q <= instr[10:8];
						state_q <= S_BASE;
					end else if (taken || is_jump ||
					             (is_cond && cond == COND_SOFT_INT)) begin
						refill_q <= REFILL_CYCLES;           // see RL4
						state_q  <= S_REFILL;
					end
				end
				S_BASE:  state_q <= (list_q == 8'h00) ? S_WBACK : S_SEL;
				S_SEL: begin
					list_q[first_set(list_q)] <= 1'b0;     // one word per listed register, see RL3
					state_q <= S_ISSUE;
				end
				S_ISSUE: state_q <= S_WAIT;
				S_WAIT: begin
					if (mem_ready) begin
						state_q <= (list_q == 8'h00) ? S_WBACK : S_SEL;
					end
				end
				S_WBACK: state_q <= S_IDLE;
				S_REFILL: begin
					refill_q <= refill_q - 2'h1;
					if (refill_q == 2'h1) begin
						state_q <= S_IDLE;
					end
				end
			endcase
		end
	end

	// busy and completion; a false condition or undefined code completes at once
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			busy_q  <= 1'b0;
			done_q  <= 1'b0;
			undef_q <= 1'b0;
		end else begin
			undef_q <= is_cond && cond == COND_UNDEF;  // see RL11
			done_q  <= (is_cond && !taken && cond != COND_SOFT_INT) ||   // see RL18
			           state_q == S_WBACK ||
			           (state_q == S_REFILL && refill_q == 2'h1);
			if (state_q == S_WBACK || (state_q == S_REFILL && refill_q == 2'h1)) begin
				busy_q <= 1'b0;
			end else if (is_multi || taken || is_jump ||
			             (is_cond && cond == COND_SOFT_INT)) begin
				busy_q <= 1'b1;
			end
		end
	end

	// memory side; stores read the register the cycle before issue
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			addr_q      <= 32'h0;
			reg_rsel_q  <= '0;
			mem_req_q   <= 1'b0;
			mem_we_q    <= 1'b0;
			mem_addr_q  <= 32'h0;
			mem_wdata_q <= 32'h0;
		end else begin
			if (is_multi) begin
				reg_rsel_q <= instr[10:8];
			end else if (state_q == S_SEL) begin
				reg_rsel_q <= first_set(list_q);
			end
			if (state_q == S_BASE) begin
				addr_q <= reg_rdata;                       // start at the base value
			end else if (state_q == S_WAIT && mem_ready) begin
				addr_q <= addr_q + WORD_BYTES;             // see RL3
			end
			if (state_q == S_ISSUE) begin
				mem_req_q   <= 1'b1;
				mem_we_q    <= !load_q;                    // see RL1
				mem_addr_q  <= addr_q;
				mem_wdata_q <= reg_rdata;
			end else if (state_q == S_WAIT && mem_ready) begin
				mem_req_q <= 1'b0;
			end
		end
	end

	// register write-back; base write follows the data so it wins if listed too
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			reg_we_q    <= 1'b0;
			reg_wsel_q  <= '0;
			reg_wdata_q <= 32'h0;
		end else begin
			reg_we_q <= 1'b0;
			if (state_q == S_WAIT && mem_ready && load_q) begin
				reg_we_q    <= 1'b1;                       // see RL2
				reg_wsel_q  <= reg_rsel_q;
				reg_wdata_q <= mem_rdata;
			end else if (state_q == S_WBACK) begin
				reg_we_q    <= 1'b1;                       // see RL1 see RL2
				reg_wsel_q  <= base_q;
				reg_wdata_q <= addr_q;
			end
		end
	end

	// flow change, link, saved status and mode; the interrupt immediate is never read
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			program_counter_load_q   <= 1'b0;
			program_counter_target_q <= 32'h0;
			link_register_we_q       <= 1'b0;
			link_register_data_q     <= 32'h0;
			saved_status_we_q        <= 1'b0;
			saved_status_register_q  <= 32'h0;
			wide_state_q             <= 1'b0;
			supervisor_mode_q        <= 1'b0;
		end else begin
			program_counter_load_q <= taken || is_jump || (is_cond && cond == COND_SOFT_INT);
			link_register_we_q     <= is_cond && cond == COND_SOFT_INT;
			saved_status_we_q      <= is_cond && cond == COND_SOFT_INT;
			if (is_cond && cond == COND_SOFT_INT) begin
				program_counter_target_q <= SOFT_INT_VEC;              // see RL12 see RL13 see RL14
				link_register_data_q     <= instr_addr + NARROW_STEP;  // see RL13
				saved_status_register_q  <= current_status_register;   // see RL13
				wide_state_q             <= 1'b1;                      // see RL13
				supervisor_mode_q        <= 1'b1;                      // see RL13
			end else if (taken) begin
				program_counter_target_q <= branch_base + short_disp;  // see RL9 see RL10
			end else if (is_jump) begin
				program_counter_target_q <= branch_base + long_disp;   // see RL15 see RL16
			end
		end
	end

	// checks
	short_branch_a: assert property (@(posedge clk) disable iff (!rst_b) // see RL10
		taken |=> program_counter_load_q &&
		program_counter_target_q == $past(instr_addr) + PREFETCH_BYTES +
		{{23{$past(instr[7])}}, $past(instr[7:0]), 1'b0})
		else $error("short branch target wrong");
	long_jump_a: assert property (@(posedge clk) disable iff (!rst_b) // see RL15
		is_jump |=> program_counter_target_q == $past(instr_addr) + PREFETCH_BYTES +
		{{20{$past(instr[10])}}, $past(instr[10:0]), 1'b0})
		else $error("jump target wrong");
	soft_int_a: assert property (@(posedge clk) disable iff (!rst_b) // see RL13
		(is_cond && cond == COND_SOFT_INT) |=> program_counter_target_q == SOFT_INT_VEC &&
		link_register_data_q == $past(instr_addr) + NARROW_STEP && supervisor_mode_q &&
		wide_state_q && saved_status_register_q == $past(current_status_register))
		else $error("interrupt entry wrong");
	undef_code_a: assert property (@(posedge clk) disable iff (!rst_b) // see RL11
		(is_cond && cond == COND_UNDEF) |=> !program_counter_load_q && undef_q)
		else $error("undefined code branched");
	not_taken_a: assert property (@(posedge clk) disable iff (!rst_b) // see RL18
		(is_cond && !taken && cond != COND_SOFT_INT) |=> done_q && !program_counter_load_q
		&& !busy_q)
		else $error("false condition not sequential");
	hi_cond_a: assert property (@(posedge clk) disable iff (!rst_b) // see RL6
		(is_cond && cond == C_HI) |-> taken == (current_status_register[FLAG_C] &&
		!current_status_register[FLAG_Z]))
		else $error("unsigned higher wrong");
	gt_cond_a: assert property (@(posedge clk) disable iff (!rst_b) // see RL8
		(is_cond && cond == C_GT) |-> taken == (!current_status_register[FLAG_Z] &&
		current_status_register[FLAG_N] == current_status_register[FLAG_V]))
		else $error("signed greater wrong");
	addr_step_a: assert property (@(posedge clk) disable iff (!rst_b) // see RL3
		(state_q == S_WAIT && mem_ready) |=> addr_q == $past(addr_q) + WORD_BYTES)
		else $error("address did not step a word");
	refill_len_a: assert property (@(posedge clk) disable iff (!rst_b) // see RL4
		$rose(program_counter_load_q) |-> ##1 busy_q ##1 done_q)
		else $error("flow change took wrong cycles");
	store_dir_a: assert property (@(posedge clk) disable iff (!rst_b) // see RL1
		$rose(mem_req_q) |-> mem_we_q == !load_q)
		else $error("transfer direction wrong");
	// multi-transfer bus and write-back; a dropped request would lose a word silently
	wback_base_a: assert property (@(posedge clk) disable iff (!rst_b) // see RL2
		state_q == S_WBACK |=> reg_we_q && reg_wsel_q == $past(base_q) &&
		reg_wdata_q == $past(addr_q))
		else $error("base write-back wrong");
	req_hold_a: assert property (@(posedge clk) disable iff (!rst_b) // see RL3
		(mem_req_q && !mem_ready) |=> mem_req_q && $stable(mem_addr_q) && $stable(mem_we_q))
		else $error("request dropped before ready");
	// main scenarios reached
	multi_cov: cover property (@(posedge clk) disable iff (!rst_b)
		state_q == S_WBACK && load_q);
	branch_cov: cover property (@(posedge clk) disable iff (!rst_b) taken);
	soft_int_cov: cover property (@(posedge clk) disable iff (!rst_b)
		is_cond && cond == COND_SOFT_INT);
	jump_cov: cover property (@(posedge clk) disable iff (!rst_b) is_jump);
	undef_cov: cover property (@(posedge clk) disable iff (!rst_b)
		is_cond && cond == COND_UNDEF);
endmodule // compact_isa_branch_multi_decode

// ---- hdl/compact_isa_pkg.sv ----
// constants, field layouts and cycle figures for the compressed branch and multi-transfer decoder
// How it works
// RL1: select bit 0 stores each listed register from base upward, then writes base back.
// RL2: select bit 1 loads each listed register from base upward, then writes base back.
// RL3: only low registers are reached; one word per listed register, addresses increasing.
// RL4: each instruction takes the cycle count of its equivalent wide-state instruction.
// RL5: codes 0000-0111 test one flag each: Z set/clear, C, N, V set/clear.
// RL6: code 1000 branches on C set and Z clear; 1001 on C clear or Z set.
// RL7: code 1010 branches when N equals V; 1011 when N differs from V.
// RL8: code 1100 needs Z clear and N equals V; 1101 Z set or N differs V.
// RL9: branch targets start from the instruction address plus four prefetch bytes.
// RL10: short offset is a signed half-word count shifted left once into 9 bits.
// RL11: code 1110 is undefined and never branches.
// RL12: code 1111 is the software interrupt, not a branch.
// RL13: interrupt saves next address to link, copies status, jumps to 0x8, wide state, supervisor.
// RL14: the interrupt's 8-bit immediate is ignored by the hardware.
// RL15: unconditional branch adds its 11-bit field shifted left once, reach plus/minus 2048.
// RL16: unconditional displacement is a 12-bit two's complement byte value, bit 0 zero.
// RL17: field layouts: multi 1100 L base list, branch 1101 cond off, jump 11100 off.
// RL18: a false condition continues sequentially and leaves the flags untouched.
package compact_isa_pkg;
	localparam logic [3:0]  MULTI_TOP      = 4'hc;  // bits 15:12
	localparam logic [3:0]  COND_TOP       = 4'hd;  // bits 15:12
	localparam logic [4:0]  JUMP_TOP       = 5'h1c; // bits 15:11
	localparam int          LOAD_BIT       = 11;
	localparam logic [3:0]  COND_UNDEF     = 4'he;
	localparam logic [3:0]  COND_SOFT_INT  = 4'hf;
	localparam logic [31:0] PREFETCH_BYTES = 32'h4;
	localparam logic [31:0] NARROW_STEP    = 32'h2;
	localparam logic [31:0] WORD_BYTES     = 32'h4;
	localparam logic [31:0] SOFT_INT_VEC   = 32'h8;
	// flag positions in the current status register
	localparam int          FLAG_N         = 31;
	localparam int          FLAG_Z         = 30;
	localparam int          FLAG_C         = 29;
	localparam int          FLAG_V         = 28;
	// pipeline refill after any change of flow, two sequential fetches
	localparam logic [1:0]  REFILL_CYCLES  = 2'h2;
	localparam logic [3:0]  C_EQ = 4'h0, C_NE = 4'h1, C_CS = 4'h2, C_CC = 4'h3;
	localparam logic [3:0]  C_MI = 4'h4, C_PL = 4'h5, C_VS = 4'h6, C_VC = 4'h7;
	localparam logic [3:0]  C_HI = 4'h8, C_LS = 4'h9, C_GE = 4'ha, C_LT = 4'hb;
	localparam logic [3:0]  C_GT = 4'hc, C_LE = 4'hd;
	typedef enum logic [2:0] {
		S_IDLE, S_BASE, S_SEL, S_ISSUE, S_WAIT, S_WBACK, S_REFILL
	} seq_state_e;
endpackage

// ---- tb/compact_isa_branch_multi_decode_test.sv ----
// self-checking bench for the compressed branch and multi-transfer decoder
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fails++; \
	$display("[FAIL] %0t got %h expected %h", $time, (g), (e)); end end
module compact_isa_branch_multi_decode_test;
	import compact_isa_pkg::*;
	logic        clk, rst_b, instr_valid, mem_ready;
	logic [15:0] instr;
	logic [31:0] instr_addr, status, reg_rdata, mem_rdata;
	logic        busy_q, done_q, undef_q, reg_we_q, mem_req_q, mem_we_q;
	logic        flow_ld_q, link_we_q, ss_we_q, wide_q, sup_q;
	logic [2:0]  rsel_q, wsel_q;
	logic [31:0] wdata_q, mem_addr_q, mem_wdata_q, flow_tgt_q, link_q, ss_q;
	logic [31:0] rf [8];
	logic [31:0] exp_addr [$];
	logic [31:0] exp_data [$];
	logic        exp_we [$];
	int          fails, check_count;
	int          link_c, stat_c, bsy_n;

	// bench register file answers the read select in the same cycle
	assign reg_rdata = rf[rsel_q];

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	compact_isa_branch_multi_decode dut (
		.clk(clk), .rst_b(rst_b), .instr_valid(instr_valid), .instr(instr),
		.instr_addr(instr_addr), .current_status_register(status), .reg_rdata(reg_rdata),
		.mem_ready(mem_ready), .mem_rdata(mem_rdata), .busy_q(busy_q), .done_q(done_q),
		.undef_q(undef_q), .reg_rsel_q(rsel_q), .reg_we_q(reg_we_q), .reg_wsel_q(wsel_q),
		.reg_wdata_q(wdata_q), .mem_req_q(mem_req_q), .mem_we_q(mem_we_q),
		.mem_addr_q(mem_addr_q), .mem_wdata_q(mem_wdata_q), .program_counter_load_q(flow_ld_q),
		.program_counter_target_q(flow_tgt_q), .link_register_we_q(link_we_q),
		.link_register_data_q(link_q), .saved_status_we_q(ss_we_q),
		.saved_status_register_q(ss_q), .wide_state_q(wide_q), .supervisor_mode_q(sup_q)
	);

	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	// offer one word, then play register file and memory until done or undefined
	task automatic run(input logic [15:0] w, output int fl_c, output int dn_c, output int un_c);
		int stall;
		fl_c = -1;
		link_c = -1;
		stat_c = -1;
		bsy_n = 0;
		dn_c = -1;
		un_c = -1;
		stall = 0;
		@(negedge clk);
		instr = w;
		instr_valid = 1'b1;
		for (int c = 1; c <= 80; c++) begin
			@(negedge clk);
			// junk offered while busy must be ignored; dropped once busy falls
			instr_valid = busy_q;
			instr = 16'($urandom);
			if (reg_we_q === 1'b1) rf[wsel_q] = wdata_q;
			if (flow_ld_q === 1'b1) fl_c = c;
			if (link_we_q === 1'b1) link_c = c;
			if (ss_we_q === 1'b1) stat_c = c;
			if (busy_q === 1'b1) bsy_n++;
			if (mem_ready) mem_ready = 1'b0;
			else if (mem_req_q === 1'b1) begin
				// random stalls so the wait state is really exercised
				if (stall > 0) stall--;
				else begin
					`CHK(mem_addr_q, exp_addr[0])
					`CHK(mem_we_q, exp_we[0])
					if (exp_we[0]) `CHK(mem_wdata_q, exp_data[0])
					else mem_rdata = exp_data[0];
					void'(exp_addr.pop_front());
					void'(exp_we.pop_front());
					void'(exp_data.pop_front());
					mem_ready = 1'b1;
					stall = $urandom % 3;
				end
			end
			if (undef_q === 1'b1) un_c = c;
			if (done_q === 1'b1) dn_c = c;
			if (dn_c > 0 || un_c > 0) return;
		end
		fails++;
		end_sim();
	endtask

	// taken branch or jump: flow change one cycle in, done three cycles in; not taken: done one cycle in
	task automatic flow(input logic [15:0] w, input logic t, input logic [31:0] d);
		logic [31:0] a;
		int p, dn, un;
		a = $urandom & 32'hffff_fffe;
		instr_addr = a;
		run(w, p, dn, un);
		if (t) begin
			`CHK(p, 1)
			`CHK(dn, 3)
			`CHK(bsy_n, 2)
			`CHK(flow_tgt_q, a + 32'h4 + d)
		end else begin
			`CHK(p, -1)
			`CHK(dn, 1)
			`CHK(bsy_n, 0)
		end
		`CHK(link_c, -1)
	endtask

	// multi transfer with expected bus words and register file built up front
	task automatic multi(input logic ld, input logic [2:0] b, input logic [7:0] l);
		logic [31:0] e [8];
		logic [31:0] ad;
		int p, dn, un;
		rf[b] = rf[b] & 32'hffff_fffc;
		e = rf;
		ad = rf[b];
		for (int i = 0; i < 8; i++) if (l[i]) begin
			exp_addr.push_back(ad);
			exp_we.push_back(!ld);
			exp_data.push_back(ld ? $urandom : rf[i]);
			if (ld) e[i] = exp_data[$];
			ad += 32'h4;
		end
		// base write-back comes last, so it wins over a loaded base
		e[b] = ad;
		run({MULTI_TOP, ld, b, l}, p, dn, un);
		`CHK(exp_addr.size(), 0)
		for (int i = 0; i < 8; i++) `CHK(rf[i], e[i])
	endtask

	initial begin
		int p, dn, un;
		logic [31:0] a;
		logic [3:0] cc;
		logic [7:0] off;
		logic [10:0] o;
		logic n, z, cy, v;
		logic [13:0] tbl;
		rst_b = 1'b0;
		instr_valid = 1'b0;
		instr = 16'h0000;
		instr_addr = 32'h0000_0000;
		status = 32'h0000_0000;
		mem_ready = 1'b0;
		mem_rdata = 32'h0000_0000;
		void'($urandom(32'h09a4));
		for (int i = 0; i < 8; i++) rf[i] = $urandom;
		repeat (4) @(negedge clk);
		rst_b = 1'b1;
		`CHK(busy_q, 1'b0)
		`CHK(wide_q, 1'b0)
		// each of the 14 branch condition codes, offset at both signed limits then random
		for (int k = 0; k < 42; k++) begin
			cc = 4'(k % 14);
			off = k < 14 ? 8'h7f : k < 28 ? 8'h80 : 8'($urandom);
			status = $urandom;
			{n, z, cy, v} = status[31:28];
			tbl = {z || n != v, !z && n == v, n != v, n == v, !cy || z, cy && !z,
				!v, v, !n, n, !cy, cy, !z, z};
			flow({COND_TOP, cc, off}, tbl[cc], {{23{off[7]}}, off, 1'b0});
		end
		// undefined code: a pulse and no flow change
		instr_addr = 32'h0000_1000;
		run({COND_TOP, COND_UNDEF, 8'h04}, p, dn, un);
		`CHK(un, 1)
		`CHK(p, -1)
		`CHK(bsy_n, 0)
		for (int k = 0; k < 6; k++) begin
			o = k == 0 ? 11'h3ff : k == 1 ? 11'h400 : k == 2 ? 11'h7fe : 11'($urandom);
			flow({JUMP_TOP, o}, 1'b1, {{20{o[10]}}, o, 1'b0});
		end
		for (int k = 0; k < 10; k++) begin
			multi(k[0], 3'($urandom), k < 2 ? 8'hff : k < 4 ? 8'h00 : 8'($urandom));
		end
		// software interrupt twice, immediates at both extremes give the same result
		for (int k = 0; k < 2; k++) begin
			a = $urandom & 32'hffff_fffe;
			instr_addr = a;
			status = $urandom;
			run({COND_TOP, COND_SOFT_INT, k ? 8'hff : 8'h00}, p, dn, un);
			`CHK(p, 1)
			`CHK(dn, 3)
			`CHK(link_c, 1)
			`CHK(stat_c, 1)
			`CHK(flow_tgt_q, SOFT_INT_VEC)
			`CHK(link_q, a + 32'h2)
			`CHK(ss_q, status)
			`CHK(wide_q, 1'b1)
			`CHK(sup_q, 1'b1)
		end
		end_sim();
	end
endmodule // compact_isa_branch_multi_decode_test
